//--- verilog/eqc_pkg.sv
// Constants for the channel 1 equalizer configuration register bank
package eqc_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] EQC_IDX_A_TAP0 = 8'h40;
	localparam logic [7:0] EQC_IDX_A_OUTPUT_DRIVE = 8'h49;
	localparam logic [7:0] EQC_IDX_A_OFFSET_CORR = 8'h4a;
	localparam logic [7:0] EQC_IDX_A_GAIN_TARGET = 8'h4b;
	localparam logic [7:0] EQC_IDX_B_TAP0 = 8'h60;
	localparam logic [7:0] EQC_IDX_B_TAP1 = 8'h61;
	localparam int EQC_NUM_A_TAPS = 9;
	localparam int EQC_NUM_B_TAPS = 2;
	localparam int EQC_NUM_REGS = 14;
	// Storage slots
	localparam int EQC_SLOT_DRIVE = 9;
	localparam int EQC_SLOT_OFFSET = 10;
	localparam int EQC_SLOT_AGC = 11;
	localparam int EQC_SLOT_B_TAP0 = 12;
	localparam logic [7:0] EQC_SLOT_IDX [0:EQC_NUM_REGS-1] = '{
		8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
		8'h49, 8'h4a, 8'h4b, 8'h60, 8'h61};
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] EQC_RST [0:EQC_NUM_REGS-1] = '{
		8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hdf, 8'hc0, 8'hc0, 8'hc0, 8'hc0,
		8'h30, 8'h40, 8'h04, 8'hc0, 8'h84};
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EQC_TAP_EN_BIT = 7;
	localparam int EQC_TAP_POS_BIT = 6;
	localparam int EQC_TAP_MAG_W = 6;
	localparam int EQC_DRIVE_W = 6;
	localparam int EQC_AUTO_OFS_BIT = 6;
	localparam int EQC_OFS_SIGN_BIT = 5;
	localparam int EQC_OFS_MAG_W = 5;
	localparam int EQC_AGC_W = 3;
	localparam logic [1:0] EQC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] EQC_HRESP_OKAY = 2'h0;
endpackage

//--- verilog/eqc_regs.sv
// Channel 1 equalizer configuration register bank on an AHB-Lite slave
//
// How it works
// R1: Tap enable in bit 7, reset set, drives tap active output.
// R2: Bit 6 is tap polarity, one positive, zero negative.
// R3: Bits 5:0 tap magnitude; array A zero except tap 4 0x1f.
// R4: Array A taps at index 0x40 plus tap number, positive reset.
// R5: Predriver gain bits 5:0, reset 0x30, driven to output stage.
// R6: Predriver bits 7:6 reserved, reset zero, no effect.
// R7: Offset bit 6 automatic correction enable reset one; bit 7 reserved.
// R8: Offset bit 5 manual correction polarity, reset zero.
// R9: Offset bits 4:0 manual magnitude, reset zero.
// R10: AGC target code bits 2:0 reset 100, bits 7:3 reserved zero.
// R11: Array B tap 0 at 0x60, enabled, positive, zero magnitude.
// R12: Array B tap 1 at 0x61, enabled, negative, magnitude 0x04.
// R13: Every bit read-write; reads return last written or reset value.
// R14: Host writes reserved bits zero and preserves them on updates.
`timescale 1ns/1ps
module eqc_regs #(
	parameter int ADDR_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [eqc_pkg::EQC_NUM_A_TAPS-1:0] a_tap_active,
	output logic [eqc_pkg::EQC_NUM_A_TAPS-1:0] a_tap_positive,
	output logic [eqc_pkg::EQC_NUM_A_TAPS*eqc_pkg::EQC_TAP_MAG_W-1:0] a_tap_magnitude,
	output logic [eqc_pkg::EQC_NUM_B_TAPS-1:0] b_tap_active,
	output logic [eqc_pkg::EQC_NUM_B_TAPS-1:0] b_tap_positive,
	output logic [eqc_pkg::EQC_NUM_B_TAPS*eqc_pkg::EQC_TAP_MAG_W-1:0] b_tap_magnitude,
	output logic [eqc_pkg::EQC_DRIVE_W-1:0] drive_gain,
	output logic auto_offset_en,
	output logic manual_offset_neg,
	output logic [eqc_pkg::EQC_OFS_MAG_W-1:0] manual_offset_mag,
	output logic [eqc_pkg::EQC_AGC_W-1:0] agc_target
);

	// Index bits 9:2 must fit in the address
	if (ADDR_W < 10) begin : g_addr_w_check
		$error("eqc_regs: ADDR_W must be at least 10");
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic [7:0] regs [0:eqc_pkg::EQC_NUM_REGS-1];
	logic addr_phase;
	logic [7:0] addr_idx;
	logic addr_hit;
	logic [3:0] addr_slot;
	logic wr_pend;
	logic [3:0] wr_slot;

	// R4: consecutive tap indices, one word each
	always_comb begin
		addr_idx = haddr[9:2];
		addr_hit = 1'b0;
		addr_slot = 4'h0;
		if ((haddr >> 10) == '0) begin
			for (int i = 0; i < eqc_pkg::EQC_NUM_REGS; i++) begin
				if (eqc_pkg::EQC_SLOT_IDX[i] == addr_idx) begin
					addr_hit = 1'b1;
					addr_slot = 4'(i);
				end
			end
		end
	end

	assign addr_phase = hsel && hready && (htrans == eqc_pkg::EQC_HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp = eqc_pkg::EQC_HRESP_OKAY[0];

	// ------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_slot <= 4'h0;
		end else begin
			wr_pend <= addr_phase && hwrite && addr_hit;
			wr_slot <= addr_slot;
		end
	end

	// R13: full byte stored, reserved bits included
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < eqc_pkg::EQC_NUM_REGS; i++) begin
				regs[i] <= eqc_pkg::EQC_RST[i];
			end
		end else if (wr_pend) begin
			regs[wr_slot] <= hwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// R13: read back, forwarding a write still in its data phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0;
		end else if (addr_phase && !hwrite) begin
			if (!addr_hit) begin
				hrdata <= 32'h0;
			end else if (wr_pend && (wr_slot == addr_slot)) begin
				hrdata <= {24'h0, hwdata[7:0]};
			end else begin
				hrdata <= {24'h0, regs[addr_slot]};
			end
		end
	end

	// ------------------------------------------------------------
	// Tap fields
	// ------------------------------------------------------------
	genvar t;
	generate
		for (t = 0; t < eqc_pkg::EQC_NUM_A_TAPS; t++) begin : g_a_tap
			// R1: tap contributes only while enabled
			assign a_tap_active[t] = regs[t][eqc_pkg::EQC_TAP_EN_BIT];
			// R2: polarity bit
			assign a_tap_positive[t] = regs[t][eqc_pkg::EQC_TAP_POS_BIT];
			// R3: unsigned magnitude
			assign a_tap_magnitude[t*eqc_pkg::EQC_TAP_MAG_W +: eqc_pkg::EQC_TAP_MAG_W] =
				regs[t][eqc_pkg::EQC_TAP_MAG_W-1:0];
		end
		for (t = 0; t < eqc_pkg::EQC_NUM_B_TAPS; t++) begin : g_b_tap
			// R11: independent second tap set
			assign b_tap_active[t] = regs[eqc_pkg::EQC_SLOT_B_TAP0+t][eqc_pkg::EQC_TAP_EN_BIT];
			// R12: own reset values per slot
			assign b_tap_positive[t] =
				regs[eqc_pkg::EQC_SLOT_B_TAP0+t][eqc_pkg::EQC_TAP_POS_BIT];
			assign b_tap_magnitude[t*eqc_pkg::EQC_TAP_MAG_W +: eqc_pkg::EQC_TAP_MAG_W] =
				regs[eqc_pkg::EQC_SLOT_B_TAP0+t][eqc_pkg::EQC_TAP_MAG_W-1:0];
		end
	endgenerate

	// ------------------------------------------------------------
	// Drive, offset and AGC fields
	// ------------------------------------------------------------
	// R5: predriver gain to output stage
	// R6: bits 7:6 stored only
	assign drive_gain = regs[eqc_pkg::EQC_SLOT_DRIVE][eqc_pkg::EQC_DRIVE_W-1:0];
	// R7: automatic offset enable; bit 7 stored only
	assign auto_offset_en = regs[eqc_pkg::EQC_SLOT_OFFSET][eqc_pkg::EQC_AUTO_OFS_BIT];
	// R8: manual offset polarity
	assign manual_offset_neg = regs[eqc_pkg::EQC_SLOT_OFFSET][eqc_pkg::EQC_OFS_SIGN_BIT];
	// R9: manual offset magnitude
	assign manual_offset_mag = regs[eqc_pkg::EQC_SLOT_OFFSET][eqc_pkg::EQC_OFS_MAG_W-1:0];
	// R10: AGC target code
	assign agc_target = regs[eqc_pkg::EQC_SLOT_AGC][eqc_pkg::EQC_AGC_W-1:0];

endmodule

//--- test/eqc_regs_asserts.sv
// Port checker for the equalizer register bank
`timescale 1ns/1ps
module eqc_regs_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [8:0] a_tap_active,
	input wire logic [8:0] a_tap_positive,
	input wire logic [5:0] drive_gain,
	input wire logic auto_offset_en,
	input wire logic [2:0] agc_target
);
	logic tk;
	logic wr_q;
	logic [7:0] idx_q;
	assign tk = hsel && hready && htrans == 2'h2;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			idx_q <= 8'h00;
		end else begin
			wr_q <= tk && hwrite;
			idx_q <= haddr[9:2];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	a_tap_enable: assert property (wr_q && idx_q == 8'h40 |=> a_tap_active[0] == $past(hwdata[7]))
		else $error("tap enable not taken");
	a_tap_sign: assert property (wr_q && idx_q == 8'h40 |=> a_tap_positive[0] == $past(hwdata[6]))
		else $error("tap sign not taken");
	a_drive_gain: assert property (wr_q && idx_q == 8'h49 |=> drive_gain == $past(hwdata[5:0]))
		else $error("drive gain not taken");
	a_auto_offset: assert property (wr_q && idx_q == 8'h4a |=> auto_offset_en == $past(hwdata[6]))
		else $error("offset enable not taken");
	a_agc_code: assert property (wr_q && idx_q == 8'h4b |=> agc_target == $past(hwdata[2:0]))
		else $error("gain target not taken");
	a_reset_fields: assert property ($rose(rst_n) |-> drive_gain == 6'h30 && agc_target == 3'h4
		&& a_tap_active == 9'h1ff && a_tap_positive == 9'h1ff && auto_offset_en)
		else $error("wrong field after reset");
	a_unmapped_zero: assert property (tk && !hwrite && haddr[9:2] == 8'h50 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	c_tap_write: cover property (wr_q && idx_q == 8'h40);
	c_read: cover property (tk && !hwrite);
	c_reset_exit: cover property ($rose(rst_n));
endmodule
bind eqc_regs eqc_regs_chk eqc_regs_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .a_tap_active(a_tap_active),
	.a_tap_positive(a_tap_positive), .drive_gain(drive_gain), .auto_offset_en(auto_offset_en),
	.agc_target(agc_target));

//--- test/test_eqc_regs.sv
// Self-checking bench for the equalizer register bank
`timescale 1ns/1ps
module test_eqc_regs;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, auto_offset_en, manual_offset_neg;
	logic [8:0] a_tap_active, a_tap_positive;
	logic [53:0] a_tap_magnitude;
	logic [1:0] b_tap_active, b_tap_positive;
	logic [11:0] b_tap_magnitude;
	logic [5:0] drive_gain;
	logic [4:0] manual_offset_mag;
	logic [2:0] agc_target;
	int err_total = 0;
	int samples_checked = 0;
	logic [7:0] rst_tab [0:13] = '{8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hdf, 8'hc0, 8'hc0, 8'hc0,
		8'hc0, 8'h30, 8'h40, 8'h04, 8'hc0, 8'h84};
	always #4 clk_sys = ~clk_sys;
	eqc_regs eqc_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .a_tap_active(a_tap_active),
		.a_tap_positive(a_tap_positive), .a_tap_magnitude(a_tap_magnitude),
		.b_tap_active(b_tap_active), .b_tap_positive(b_tap_positive),
		.b_tap_magnitude(b_tap_magnitude), .drive_gain(drive_gain),
		.auto_offset_en(auto_offset_en), .manual_offset_neg(manual_offset_neg),
		.manual_offset_mag(manual_offset_mag), .agc_target(agc_target));
	// ----------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------
	function automatic logic [7:0] idx(input int i);
		return i < 12 ? 8'h40 + i[7:0] : 8'h54 + i[7:0];
	endfunction
	function automatic logic [7:0] val(input int i);
		logic [7:0] v;
		v = {i[3:0], i[3:0] ^ 4'h9};
		return i == 9 ? v & 8'h3f : i == 10 ? v & 8'h7f : i == 11 ? v & 8'h07 : v;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, a, 2'b00};
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys);
		err_total++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			check(32'(a_tap_magnitude[31:0]), 32'h1f000000);
			check(32'(a_tap_magnitude[53:32]), 32'h0);
			check(32'({b_tap_active, b_tap_positive, b_tap_magnitude}), 32'hd100);
			check(32'({manual_offset_neg, manual_offset_mag}), 32'h0);
			for (int i = 0; i < 14; i++) begin
				xfer(1'b0, idx(i), 32'h0);
				check(rd, {24'h0, rst_tab[i]});
			end
			for (int i = 0; i < 14; i++) xfer(1'b1, idx(i), {24'hffffff, val(i)});
			for (int i = 0; i < 14; i++) begin
				xfer(1'b0, idx(i), 32'h0);
				check(rd, {24'h0, val(i)});
			end
			check(32'(a_tap_active), 32'h100);
			check(32'(a_tap_positive), 32'h0f0);
			check(32'(a_tap_magnitude[53:48]), 32'h01);
			check(32'(drive_gain), 32'h10);
			check(32'({auto_offset_en, manual_offset_neg, manual_offset_mag}), 32'h23);
			check(32'(agc_target), 32'h2);
			check(32'(b_tap_magnitude), 32'h505);
			check(32'({b_tap_active, b_tap_positive}), 32'hf);
			xfer(1'b1, 8'h50, 32'h5a);
			xfer(1'b0, 8'h50, 32'h0);
			check(rd, 32'h0);
			rst_n <= 1'b0;
			@(posedge clk_sys);
			rst_n <= 1'b1;
		end
		conclude();
	end
endmodule
